// [include/typeb_defs.svh]
// Constants for the Type B attribute/halt handler pair.
// Assumes inclusion by bare name from both ends, the checker and the bench.
`ifndef TYPEB_DEFS_SVH
`define TYPEB_DEFS_SVH

// Command and response codes
`define TB_CMD_ATTRIB 8'h1D
`define TB_CMD_HLTB 8'h50
`define TB_RSP_ATTRIB 8'h10
`define TB_RSP_HLTB 8'h00

// Frame lengths without CRC_B, in bytes
`define TB_ATTRIB_LEN 4'h9
`define TB_HLTB_LEN 4'h5

// Byte positions within a frame
`define TB_POS_CMD 4'h0
`define TB_POS_ID_LAST 4'h4
`define TB_POS_PARAM1 4'h5
`define TB_POS_PARAM2 4'h6
`define TB_POS_PARAM3 4'h7
`define TB_POS_PARAM4 4'h8

// Param2 field layout and codes
`define TB_P2_TX_RATE_MSB 7
`define TB_P2_TX_RATE_LSB 6
`define TB_P2_RX_RATE_MSB 5
`define TB_P2_RX_RATE_LSB 4
`define TB_P2_FSDI_MSB 3
`define TB_P2_FSDI_LSB 0
`define TB_RATE_106 2'h0
`define TB_RATE_212 2'h1
`define TB_RATE_424 2'h2
`define TB_RATE_FORBIDDEN 2'h3
`define TB_FSDI_256 4'h8

// Param3 and Param4 layout and codes
`define TB_P3_RFU_MSB 7
`define TB_P3_RFU_LSB 4
`define TB_P3_PROTO_BIT 0
`define TB_P4_CID_MSB 3
`define TB_P4_CID_LSB 0
`define TB_NIBBLE_ZERO 4'h0

// Fixed Param values sent by the reader end
`define TB_PARAM1_VALUE 8'h00
`define TB_PARAM4_VALUE 8'h00

// Reader wait for an answer, in clock cycles
`define TB_RSP_WAIT_CYCLES 8'h20

`endif

// [include/typeb_pkg.sv]
// Types shared by the two ends of the Type B link.
// Assumes nothing beyond a SystemVerilog compiler.
package typeb_pkg;

    // Tag protocol state, Gray along ready -> active -> halt
    typedef enum logic [1:0] {
        TAG_READY = 2'b00,
        TAG_ACTIVE = 2'b01,
        TAG_HALT = 2'b11
    } tag_state_e;

    // Reader sequencer, Gray along idle -> send -> wait -> done
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_SEND = 2'b01,
        RD_WAIT = 2'b11,
        RD_DONE = 2'b10
    } rd_state_e;

    typedef logic [7:0] byte_t;

endpackage

// [include/typeb_link_if.sv]
// Byte-level Type B link between reader end and tag end.
// Assumes an outside framer adds and checks CRC_B; both ends share one clock.
`timescale 1ns/1ns
`default_nettype none

interface typeb_link_if;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_last;
    logic cmd_crc_ok;
    logic rsp_valid;
    logic [7:0] rsp_data;

    modport tag (
        input cmd_valid,
        input cmd_data,
        input cmd_last,
        input cmd_crc_ok,
        output rsp_valid,
        output rsp_data
    );

    modport reader (
        output cmd_valid,
        output cmd_data,
        output cmd_last,
        output cmd_crc_ok,
        input rsp_valid,
        input rsp_data
    );
endinterface

`default_nettype wire

// [design/typeb_tag_end.sv]
// Tag end: checks ATTRIB and HLTB frames and builds the one-byte answer.
// Assumes the framer strips CRC_B, flags its result with the last byte,
// and appends CRC_B to every answer byte it is handed.
//
// Contract
// - Rate fields equal and not 11b, else silent
// - Unsupported Param2 setting gets no answer
// - Reader codes frame size 0000b..1000b; the reader end passes any fsdi_in through unchecked
// - Reader sets Param3 protocol nibble, upper zero
// - Answer only if Param3 upper zero, bit0 set
// - Silent unless Param4 low nibble zero
// - Accepted ATTRIB answers 0x10 plus CRC_B
// - HLTB with own PUPI halts, answers 0x00
// - ATTRIB code 0x1D moves tag to active
`timescale 1ns/1ns
`include "typeb_defs.svh"
`default_nettype none

module typeb_tag_end (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Link to the reader
    typeb_link_if.tag link,
    // Tag identity and wake-up from the anticollision logic
    input wire logic [31:0] pupi_in,
    input wire logic wake_in,
    // Tag status
    output logic active_out,
    output logic halted_out,
    output logic accept_out
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typeb_pkg::tag_state_e st_ff;
    typeb_pkg::tag_state_e nxt_st;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd;
    logic id_ok_ff;
    logic nxt_id_ok;
    logic [7:0] p2_ff;
    logic [7:0] nxt_p2;
    logic [7:0] p3_ff;
    logic [7:0] nxt_p3;
    logic rsp_valid_ff;
    logic nxt_rsp_valid;
    logic [7:0] rsp_data_ff;
    logic [7:0] nxt_rsp_data;
    logic accept_ff;
    logic nxt_accept;

    ////////////////////////////////////////////////////////////////////////
    // Frame checks

    logic [7:0] cmd_now;
    logic [3:0] frame_len;
    logic [7:0] pupi_byte;
    logic p2_ok;
    logic p3_ok;
    logic p4_ok;
    logic attrib_ok;
    logic hltb_ok;

    // Identifier bytes arrive most significant first
    always_comb begin
        case (idx_ff)
            4'h1: pupi_byte = pupi_in[31:24];
            4'h2: pupi_byte = pupi_in[23:16];
            4'h3: pupi_byte = pupi_in[15:8];
            4'h4: pupi_byte = pupi_in[7:0];
            default: pupi_byte = 8'h00;
        endcase
    end

    always_comb begin
        cmd_now = (idx_ff == `TB_POS_CMD) ? link.cmd_data : cmd_ff;
        frame_len = idx_ff + 4'h1;
        // Both rates must match and neither may be the forbidden code
        p2_ok = (p2_ff[`TB_P2_TX_RATE_MSB:`TB_P2_TX_RATE_LSB] != `TB_RATE_FORBIDDEN)
            && (p2_ff[`TB_P2_TX_RATE_MSB:`TB_P2_TX_RATE_LSB]
                == p2_ff[`TB_P2_RX_RATE_MSB:`TB_P2_RX_RATE_LSB])
            && (p2_ff[`TB_P2_FSDI_MSB:`TB_P2_FSDI_LSB] <= `TB_FSDI_256);
        // Protocol nibble bits 3-1 are don't-care
        p3_ok = (p3_ff[`TB_P3_RFU_MSB:`TB_P3_RFU_LSB] == `TB_NIBBLE_ZERO)
            && p3_ff[`TB_P3_PROTO_BIT];
        // No card identifier; the upper nibble is don't-care
        p4_ok = (link.cmd_data[`TB_P4_CID_MSB:`TB_P4_CID_LSB] == `TB_NIBBLE_ZERO);
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte capture

    always_comb begin
        nxt_idx = idx_ff;
        nxt_cmd = cmd_ff;
        nxt_id_ok = id_ok_ff;
        nxt_p2 = p2_ff;
        nxt_p3 = p3_ff;
        if (link.cmd_valid) begin
            if (idx_ff != 4'hF) begin
                nxt_idx = idx_ff + 4'h1;
            end
            case (idx_ff)
                `TB_POS_CMD: begin
                    nxt_cmd = link.cmd_data;
                    nxt_id_ok = 1'b1;
                end
                4'h1, 4'h2, 4'h3, `TB_POS_ID_LAST: begin
                    nxt_id_ok = id_ok_ff && (link.cmd_data == pupi_byte);
                end
                `TB_POS_PARAM2: begin
                    nxt_p2 = link.cmd_data;
                end
                `TB_POS_PARAM3: begin
                    nxt_p3 = link.cmd_data;
                end
                default: begin
                    nxt_cmd = cmd_ff;
                end
            endcase
            // Param1 timing options are not used by this tag
            if (link.cmd_last) begin
                nxt_idx = 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decision and answer

    always_comb begin
        attrib_ok = link.cmd_valid && link.cmd_last
            && (cmd_now == `TB_CMD_ATTRIB)
            && (frame_len == `TB_ATTRIB_LEN)
            && link.cmd_crc_ok
            && (st_ff != typeb_pkg::TAG_HALT)
            && nxt_id_ok && p2_ok && p3_ok && p4_ok;
        hltb_ok = link.cmd_valid && link.cmd_last
            && (cmd_now == `TB_CMD_HLTB)
            && (frame_len == `TB_HLTB_LEN)
            && link.cmd_crc_ok
            && (st_ff != typeb_pkg::TAG_HALT)
            && nxt_id_ok;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data = rsp_data_ff;
        nxt_accept = 1'b0;
        case (st_ff)
            typeb_pkg::TAG_READY, typeb_pkg::TAG_ACTIVE: begin
                if (hltb_ok) begin
                    nxt_st = typeb_pkg::TAG_HALT;
                    nxt_rsp_valid = 1'b1;
                    nxt_rsp_data = `TB_RSP_HLTB;
                end else if (attrib_ok) begin
                    nxt_st = typeb_pkg::TAG_ACTIVE;
                    nxt_rsp_valid = 1'b1;
                    nxt_rsp_data = `TB_RSP_ATTRIB;
                    nxt_accept = 1'b1;
                end
            end
            typeb_pkg::TAG_HALT: begin
                // Only the outside wake-up leaves halt; frames fall through silently
                if (wake_in) begin
                    nxt_st = typeb_pkg::TAG_READY;
                end
            end
            default: begin
                nxt_st = typeb_pkg::TAG_READY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_ff <= typeb_pkg::TAG_READY;
            idx_ff <= 4'h0;
            cmd_ff <= 8'h00;
            id_ok_ff <= 1'b0;
            p2_ff <= 8'h00;
            p3_ff <= 8'h00;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            accept_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            cmd_ff <= nxt_cmd;
            id_ok_ff <= nxt_id_ok;
            p2_ff <= nxt_p2;
            p3_ff <= nxt_p3;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            accept_ff <= nxt_accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // The answer is one byte; the framer appends the two CRC_B bytes
    assign link.rsp_valid = rsp_valid_ff;
    assign link.rsp_data = rsp_data_ff;
    assign active_out = (st_ff == typeb_pkg::TAG_ACTIVE);
    assign halted_out = (st_ff == typeb_pkg::TAG_HALT);
    assign accept_out = accept_ff;

endmodule

`default_nettype wire

// [design/typeb_reader_end.sv]
// Reader end: sends one ATTRIB or HLTB frame and waits for the tag's answer.
// Assumes the framer appends CRC_B; crc_good_in lets a user spoil it.
`timescale 1ns/1ns
`include "typeb_defs.svh"
`default_nettype none

module typeb_reader_end #(
    parameter logic [7:0] RSP_WAIT = `TB_RSP_WAIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Link to the tag
    typeb_link_if.reader link,
    // Requests
    input wire logic start_attrib_in,
    input wire logic start_hltb_in,
    input wire logic [31:0] pupi_in,
    input wire logic [1:0] rate_in,
    input wire logic [3:0] fsdi_in,
    input wire logic [3:0] proto_in,
    input wire logic crc_good_in,
    // Results
    output logic busy_out,
    output logic done_out,
    output logic answered_out,
    output logic [7:0] rsp_byte_out
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typeb_pkg::rd_state_e st_ff;
    typeb_pkg::rd_state_e nxt_st;
    typeb_pkg::byte_t frame_ff [0:8];
    typeb_pkg::byte_t nxt_frame [0:8];
    logic [3:0] len_ff;
    logic [3:0] nxt_len;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic crc_ff;
    logic nxt_crc;
    logic [7:0] wait_ff;
    logic [7:0] nxt_wait;
    logic ans_ff;
    logic nxt_ans;
    logic [7:0] rsp_ff;
    logic [7:0] nxt_rsp;

    always_comb begin
        nxt_st = st_ff;
        nxt_frame = frame_ff;
        nxt_len = len_ff;
        nxt_idx = idx_ff;
        nxt_crc = crc_ff;
        nxt_wait = wait_ff;
        nxt_ans = ans_ff;
        nxt_rsp = rsp_ff;
        case (st_ff)
            typeb_pkg::RD_IDLE, typeb_pkg::RD_DONE: begin
                nxt_st = typeb_pkg::RD_IDLE;
                if (start_attrib_in || start_hltb_in) begin
                    nxt_frame[0] = start_hltb_in ? `TB_CMD_HLTB : `TB_CMD_ATTRIB;
                    nxt_frame[1] = pupi_in[31:24];
                    nxt_frame[2] = pupi_in[23:16];
                    nxt_frame[3] = pupi_in[15:8];
                    nxt_frame[4] = pupi_in[7:0];
                    nxt_frame[5] = `TB_PARAM1_VALUE;
                    nxt_frame[6] = {rate_in, rate_in, fsdi_in};
                    nxt_frame[7] = {`TB_NIBBLE_ZERO, proto_in};
                    nxt_frame[8] = `TB_PARAM4_VALUE;
                    nxt_len = start_hltb_in ? `TB_HLTB_LEN : `TB_ATTRIB_LEN;
                    nxt_idx = 4'h0;
                    nxt_crc = crc_good_in;
                    nxt_ans = 1'b0;
                    nxt_st = typeb_pkg::RD_SEND;
                end
            end
            typeb_pkg::RD_SEND: begin
                nxt_idx = idx_ff + 4'h1;
                if (idx_ff == len_ff - 4'h1) begin
                    nxt_wait = 8'h00;
                    nxt_st = typeb_pkg::RD_WAIT;
                end
            end
            typeb_pkg::RD_WAIT: begin
                nxt_wait = wait_ff + 8'h01;
                if (link.rsp_valid) begin
                    nxt_ans = 1'b1;
                    nxt_rsp = link.rsp_data;
                    nxt_st = typeb_pkg::RD_DONE;
                end else if (wait_ff == RSP_WAIT) begin
                    nxt_st = typeb_pkg::RD_DONE;
                end
            end
            default: begin
                nxt_st = typeb_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_ff <= typeb_pkg::RD_IDLE;
            for (int i = 0; i < 9; i++) begin
                frame_ff[i] <= 8'h00;
            end
            len_ff <= 4'h0;
            idx_ff <= 4'h0;
            crc_ff <= 1'b0;
            wait_ff <= 8'h00;
            ans_ff <= 1'b0;
            rsp_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            frame_ff <= nxt_frame;
            len_ff <= nxt_len;
            idx_ff <= nxt_idx;
            crc_ff <= nxt_crc;
            wait_ff <= nxt_wait;
            ans_ff <= nxt_ans;
            rsp_ff <= nxt_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic sending;
    assign sending = (st_ff == typeb_pkg::RD_SEND);
    assign link.cmd_valid = sending;
    assign link.cmd_data = sending ? frame_ff[idx_ff] : 8'h00;
    assign link.cmd_last = sending && (idx_ff == len_ff - 4'h1);
    assign link.cmd_crc_ok = sending && crc_ff;
    assign busy_out = (st_ff == typeb_pkg::RD_SEND) || (st_ff == typeb_pkg::RD_WAIT);
    assign done_out = (st_ff == typeb_pkg::RD_DONE);
    assign answered_out = ans_ff;
    assign rsp_byte_out = rsp_ff;

endmodule

`default_nettype wire

// [testbench/typeb_link_properties.sv]
// Checker for the link between the reader end and the tag end.
// Assumes the reader sends its bytes on consecutive cycles, as it does.
`timescale 1ns/1ns
`include "typeb_defs.svh"
`default_nettype none

module typeb_link_properties (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    input wire logic cmd_crc_ok,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////////
    // Frame tracking: code byte and the two bytes before the last one
    logic first_ff, nxt_first;
    logic [7:0] code_ff, nxt_code, d1_ff, nxt_d1, d2_ff, nxt_d2;
    logic end_ok, attr_end;

    always_comb begin
        nxt_first = cmd_valid ? cmd_last : first_ff;
        nxt_code = (cmd_valid && first_ff) ? cmd_data : code_ff;
        nxt_d1 = cmd_valid ? cmd_data : d1_ff;
        nxt_d2 = cmd_valid ? d1_ff : d2_ff;
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            first_ff <= 1'b1;
            code_ff <= 8'h00;
            d1_ff <= 8'h00;
            d2_ff <= 8'h00;
        end else begin
            first_ff <= nxt_first;
            code_ff <= nxt_code;
            d1_ff <= nxt_d1;
            d2_ff <= nxt_d2;
        end
    end

    // Last byte of an ATTRIB: d1 is Param3, d2 is Param2
    assign end_ok = cmd_valid && cmd_last && cmd_crc_ok;
    assign attr_end = cmd_valid && cmd_last && code_ff == `TB_CMD_ATTRIB;

    ////////////////////////////////////////////////////////////////////////
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    rsp_cause_a: assert property (rsp_valid |-> $past(end_ok))
        else $error("answer without a good frame end");
    crc_drop_a: assert property (cmd_valid && cmd_last && !cmd_crc_ok |=> !rsp_valid)
        else $error("answer to a bad CRC frame");
    attrib_answer_a: assert property (rsp_valid && code_ff == `TB_CMD_ATTRIB |-> rsp_data == 8'h10)
        else $error("wrong ATTRIB answer byte");
    halt_answer_a: assert property (rsp_valid && code_ff == `TB_CMD_HLTB |-> rsp_data == 8'h00)
        else $error("wrong HLTB answer byte");
    rate_bad_a: assert property (attr_end
        && (d2_ff[7:6] != d2_ff[5:4] || d2_ff[7:6] == 2'h3) |=> !rsp_valid)
        else $error("answer to a bad rate setting");
    frame_size_a: assert property (attr_end && d2_ff[3:0] > 4'h8 |=> !rsp_valid)
        else $error("answer to an unsupported frame size");
    param3_bad_a: assert property (attr_end && (d1_ff[7:4] != 4'h0 || !d1_ff[0]) |=> !rsp_valid)
        else $error("answer to a bad Param3");
    param3_rfu_a: assert property (attr_end |-> d1_ff[7:4] == 4'h0)
        else $error("reader sent Param3 upper nibble");
    hltb_len_a: assert property (cmd_valid && first_ff
        && cmd_data == 8'h50 |-> ##4 (cmd_valid && cmd_last))
        else $error("HLTB frame not five bytes");
    attrib_len_a: assert property (cmd_valid && first_ff
        && cmd_data == 8'h1D |-> ##8 (cmd_valid && cmd_last))
        else $error("ATTRIB frame not nine bytes");
endmodule

`default_nettype wire

// [testbench/test_typeb_attrib_halt_handler.sv]
// Bench for the reader end and tag end joined by one link.
// Assumes a second tag end on its own link, driven byte by byte here.
`timescale 1ns/1ns
`include "typeb_defs.svh"
`default_nettype none

module test_typeb_attrib_halt_handler;
    // Arbitrary identifier value
    localparam logic [31:0] PUPI = 32'hA5C3_1E77;
    typedef struct packed {
        logic hltb;
        logic [1:0] rate;
        logic [3:0] fsdi;
        logic [3:0] proto;
        logic crc;
        logic own;
        logic ans;
        logic act;
        logic hlt;
    } row_s;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start_attrib, start_hltb, crc_good, wake, own;
    logic [1:0] rate;
    logic [3:0] fsdi, proto;
    logic busy, done, answered, act, hlt, acc, act2, hlt2, acc2;
    logic [7:0] rsp_byte;
    int n_errors = 0;
    int n_tests = 0;
    row_s rows [12];

    always #20 mclk_in = ~mclk_in;

    ////////////////////////////////////////////////////////////////////////
    typeb_link_if link();
    typeb_link_if link2();

    typeb_reader_end #(.RSP_WAIT(8'h04)) u_typeb_reader_end (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .link(link), .start_attrib_in(start_attrib), .start_hltb_in(start_hltb),
        .pupi_in(own ? PUPI : ~PUPI), .rate_in(rate), .fsdi_in(fsdi), .proto_in(proto),
        .crc_good_in(crc_good), .busy_out(busy), .done_out(done), .answered_out(answered),
        .rsp_byte_out(rsp_byte));
    typeb_tag_end u_typeb_tag_end (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link),
        .pupi_in(PUPI), .wake_in(wake), .active_out(act), .halted_out(hlt), .accept_out(acc));
    // Second tag takes malformed frames the reader end cannot make
    typeb_tag_end u_typeb_tag_end_2 (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link2),
        .pupi_in(PUPI), .wake_in(1'b0), .active_out(act2), .halted_out(hlt2), .accept_out(acc2));
    typeb_link_properties u_typeb_link_properties (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
        .cmd_crc_ok(link.cmd_crc_ok), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One request through the reader end; bounded wait for done
    task automatic run_row(input row_s r);
        logic seen_done;
        logic seen_acc;
        seen_done = 1'b0;
        seen_acc = 1'b0;
        @(negedge mclk_in);
        start_hltb = r.hltb;
        start_attrib = ~r.hltb;
        rate = r.rate;
        fsdi = r.fsdi;
        proto = r.proto;
        crc_good = r.crc;
        own = r.own;
        for (int k = 0; k < 40 && !seen_done; k++) begin
            @(negedge mclk_in);
            start_attrib = 1'b0;
            start_hltb = 1'b0;
            if (k == 0) begin
                check("busy", busy, 1'b1);
            end
            seen_acc = seen_acc | (acc === 1'b1);
            seen_done = (done === 1'b1);
        end
        check("done", seen_done, 1'b1);
        if (!seen_done) begin
            test_done();
        end
        check("answered", answered, r.ans);
        if (r.ans) begin
            check("rsp_byte", rsp_byte, r.hltb ? `TB_RSP_HLTB : `TB_RSP_ATTRIB);
        end
        check("accept", seen_acc, r.ans & ~r.hltb);
        check("active", act, r.act);
        check("halted", hlt, r.hlt);
    endtask

    // Nine-byte frame straight into the second tag, good CRC
    task automatic tag_frame(input logic [71:0] f, input logic exp);
        for (int i = 0; i < 9; i++) begin
            @(negedge mclk_in);
            link2.cmd_valid = 1'b1;
            link2.cmd_data = f[71 - 8 * i -: 8];
            link2.cmd_last = (i == 8);
        end
        // The answer stands for one cycle only: look while it stands
        @(negedge mclk_in);
        check("tag_rsp", link2.rsp_valid, exp);
        check("tag_acc", acc2, exp);
        if (exp) begin
            check("tag_data", link2.rsp_data, `TB_RSP_ATTRIB);
        end
        link2.cmd_valid = 1'b0;
        link2.cmd_last = 1'b0;
        link2.cmd_data = 8'h00;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        start_attrib = 1'b0;
        start_hltb = 1'b0;
        crc_good = 1'b1;
        wake = 1'b0;
        own = 1'b1;
        rate = 2'h0;
        fsdi = 4'h0;
        proto = 4'h1;
        link2.cmd_valid = 1'b0;
        link2.cmd_data = 8'h00;
        link2.cmd_last = 1'b0;
        link2.cmd_crc_ok = 1'b1;
        // Refusals first, while the tag is still ready
        rows[0] = '{1'b0, 2'h3, 4'h0, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[1] = '{1'b0, 2'h0, 4'h9, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[2] = '{1'b0, 2'h0, 4'h0, 4'hE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[3] = '{1'b0, 2'h0, 4'h0, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[4] = '{1'b0, 2'h0, 4'h0, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[5] = '{1'b1, 2'h0, 4'h0, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[6] = '{1'b0, 2'h0, 4'h8, 4'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        rows[7] = '{1'b0, 2'h1, 4'h0, 4'hF, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        rows[8] = '{1'b0, 2'h2, 4'h5, 4'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        rows[9] = '{1'b1, 2'h0, 4'h0, 4'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        rows[10] = '{1'b1, 2'h0, 4'h0, 4'h1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        rows[11] = '{1'b0, 2'h0, 4'h8, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        repeat (4) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        check("rst_state", {act, hlt, acc, link.rsp_valid, busy, done, answered}, 7'h00);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Wake-up returns the halted tag to ready, so ATTRIB works again
        @(negedge mclk_in);
        wake = 1'b1;
        @(negedge mclk_in);
        wake = 1'b0;
        check("woken", {act, hlt}, 2'h0);
        run_row(rows[6]);
        tag_frame({`TB_CMD_ATTRIB, PUPI, 8'h00, 8'h40, 8'h01, 8'h00}, 1'b0);
        tag_frame({`TB_CMD_ATTRIB, PUPI, 8'h00, 8'h00, 8'h11, 8'h00}, 1'b0);
        tag_frame({`TB_CMD_ATTRIB, PUPI, 8'h00, 8'h00, 8'h01, 8'h01}, 1'b0);
        tag_frame({8'h1E, PUPI, 8'h00, 8'h00, 8'h01, 8'h00}, 1'b0);
        tag_frame({`TB_CMD_ATTRIB, PUPI, 8'h00, 8'h00, 8'h01, 8'hF0}, 1'b1);
        check("active2", act2, 1'b1);
        // Reset in mid-run drops both tags back to ready
        @(negedge mclk_in);
        sys_rst_in = 1'b1;
        @(negedge mclk_in);
        sys_rst_in = 1'b0;
        check("rst_again", {act, act2, hlt2, link2.rsp_valid}, 4'h0);
        test_done();
    end
endmodule

`default_nettype wire
